// *** rtl/trr_top.v ***
// Temperature result registers with APB slave, freeze logic and limit status
`timescale 1ns/1ps
`default_nettype none
`include "trr_map.vh"

module trr_top (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [9:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output wire o_pslverr,
  output wire [31:0] o_prdata,
  // Measurement from the converter
  input wire i_meas_valid,
  input wire [1:0] i_meas_chan,
  input wire [9:0] i_meas_temp,
  input wire i_meas_fault,
  // Status outputs
  output wire o_alert_n,
  output wire o_frozen
);

  // --------------------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------------------
  // Channel whose limit, offset or reading register an index names; 3 = none
  function [1:0] chan_of;
    input [7:0] idx;
    input [7:0] base;
    input [1:0] step;
    begin
      if (idx == base) begin
        chan_of = 2'h0;
      end else if (idx == base + {6'h00, step}) begin
        chan_of = 2'h1;
      end else if (idx == base + {5'h00, step, 1'b0}) begin
        chan_of = 2'h2;
      end else begin
        chan_of = 2'h3;
      end
    end
  endfunction

  wire [7:0] idx = i_paddr[9:2];
  wire aligned = (i_paddr[1:0] == 2'h0);
  wire [1:0] lo_ch = chan_of(idx, `TRR_IDX_R1_LOW, 2'h2);
  wire [1:0] hi_ch = chan_of(idx, `TRR_IDX_R1_HIGH, 2'h2);
  wire [1:0] off_ch = chan_of(idx, `TRR_IDX_R1_OFFSET, 2'h1);
  wire [1:0] rd_ch = chan_of(idx, `TRR_IDX_R1_READ, 2'h1);

  // --------------------------------------------------------------------------
  // Bus phases
  // --------------------------------------------------------------------------
  // Read data is captured in the setup cycle so the access phase needs no wait
  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire wr_done = access & i_pwrite;
  wire rd_done = access & ~i_pwrite;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg [7:0] lim_lo_ff [0:2];
  reg [7:0] lim_hi_ff [0:2];
  reg [7:0] off_ff [0:2];
  reg [9:0] read_ff [0:2];
  reg [9:0] pend_code_ff [0:2];
  reg [1:0] cfg_ff;
  reg [5:0] mask_ff;
  reg [5:0] sts_ff;
  reg alert_en_ff;
  reg alert_ff;
  reg freeze_ff;
  reg [2:0] unread_ff;
  reg [31:0] prdata_ff;
  reg pslverr_ff;

  wire compat = cfg_ff[`TRR_CFG_COMPAT_BIT];
  wire half_step = cfg_ff[`TRR_CFG_HALF_STEP_BIT];

  // --------------------------------------------------------------------------
  // Measurement path
  // --------------------------------------------------------------------------
  // One converter result per cycle; channel code 3 is dropped
  wire meas_ok = i_meas_valid & (i_meas_chan != 2'h3);
  wire [1:0] mch = (i_meas_chan == 2'h3) ? 2'h0 : i_meas_chan;
  wire [9:0] meas_code;
  wire meas_lo;
  wire meas_hi;

  trr_channel u_channel (
    .i_raw(i_meas_temp),
    .i_fault(i_meas_fault),
    .i_offset(off_ff[mch]),
    .i_half_step(half_step),
    .i_compat(compat),
    .i_lim_lo(lim_lo_ff[mch]),
    .i_lim_hi(lim_hi_ff[mch]),
    .o_code(meas_code),
    .o_lo_viol(meas_lo),
    .o_hi_viol(meas_hi)
  );

  // --------------------------------------------------------------------------
  // Freeze control
  // --------------------------------------------------------------------------
  // Freeze also covers the fraction read in flight, so its captured bits
  // and the reading registers cannot drift apart before the flag sets
  wire frac_sel = i_psel & ~i_pwrite & aligned & (idx == `TRR_IDX_FRACTION);
  wire frozen = freeze_ff | frac_sel;
  reg nxt_freeze;
  reg [2:0] nxt_unread;

  always @* begin
    nxt_freeze = freeze_ff;
    nxt_unread = unread_ff;
    if (rd_done && aligned && idx == `TRR_IDX_FRACTION) begin
      nxt_freeze = 1'b1;
      nxt_unread = 3'h7;
    end else if (rd_done && aligned && rd_ch != 2'h3 && freeze_ff) begin
      nxt_unread[rd_ch] = 1'b0;
      if ((unread_ff & ~(3'h1 << rd_ch)) == 3'h0) begin
        nxt_freeze = 1'b0;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      freeze_ff <= 1'b0;
      unread_ff <= 3'h0;
    end else begin
      freeze_ff <= nxt_freeze;
      unread_ff <= nxt_unread;
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel registers
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `TRR_NUM_CHAN; g = g + 1) begin : g_chan
      wire wr_lo = wr_done & aligned & (lo_ch == g);
      wire wr_hi = wr_done & aligned & (hi_ch == g);
      wire wr_off = wr_done & aligned & (off_ch == g);
      wire new_meas = meas_ok & (mch == g);
      reg pend_vld_ff;

      // Limits and offsets written by software
      always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          lim_lo_ff[g] <= `TRR_RST_LOW_LIMIT;
          lim_hi_ff[g] <= `TRR_RST_HIGH_LIMIT;
          off_ff[g] <= `TRR_RST_OFFSET;
        end else begin
          if (wr_lo) begin
            lim_lo_ff[g] <= i_pwdata[7:0];
          end
          if (wr_hi) begin
            lim_hi_ff[g] <= i_pwdata[7:0];
          end
          if (wr_off) begin
            off_ff[g] <= i_pwdata[7:0];
          end
        end
      end

      // Readings; a frozen channel parks its newest result
      always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          read_ff[g] <= `TRR_RST_READING;
          pend_code_ff[g] <= `TRR_RST_READING;
          pend_vld_ff <= 1'b0;
        end else if (frozen) begin
          if (new_meas) begin
            pend_code_ff[g] <= meas_code;
            pend_vld_ff <= 1'b1;
          end
        end else if (new_meas) begin
          read_ff[g] <= meas_code;
          pend_vld_ff <= 1'b0;
        end else if (pend_vld_ff) begin
          read_ff[g] <= pend_code_ff[g];
          pend_vld_ff <= 1'b0;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Configuration, mask and alert control
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cfg_ff <= `TRR_RST_CONFIG;
      mask_ff <= `TRR_RST_MASK;
      alert_en_ff <= `TRR_RST_ALERT_CTRL;
    end else if (wr_done && aligned) begin
      if (idx == `TRR_IDX_CONFIG) begin
        cfg_ff <= i_pwdata[1:0];
      end
      if (idx == `TRR_IDX_MASK) begin
        mask_ff <= i_pwdata[5:0];
      end
      if (idx == `TRR_IDX_ALERT_CTRL) begin
        alert_en_ff <= i_pwdata[`TRR_ALERT_EN_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sticky status and alert
  // --------------------------------------------------------------------------
  // Write one to clear; a violation in the clearing cycle still lands
  wire [5:0] sts_set = meas_ok ? ({4'h0, meas_hi, meas_lo} << {mch, 1'b0}) : 6'h00;
  wire [5:0] sts_clr = (wr_done && aligned && idx == `TRR_IDX_STATUS) ? i_pwdata[5:0] : 6'h00;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sts_ff <= `TRR_RST_STATUS;
      alert_ff <= 1'b0;
    end else begin
      sts_ff <= (sts_ff & ~sts_clr) | sts_set;
      alert_ff <= alert_en_ff & (|(sts_ff & ~mask_ff));
    end
  end

  assign o_alert_n = ~alert_ff;
  assign o_frozen = freeze_ff;

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  // Whole-degree readings carry no side effect unless a freeze is pending
  reg [7:0] rd_val;
  reg rd_hit;

  always @* begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (idx)
      `TRR_IDX_R1_READ: begin
        rd_val = read_ff[0][9:2];
      end
      `TRR_IDX_LOC_READ: begin
        rd_val = read_ff[1][9:2];
      end
      `TRR_IDX_R2_READ: begin
        rd_val = read_ff[2][9:2];
      end
      `TRR_IDX_FRACTION: begin
        rd_val = {read_ff[2][1:0], read_ff[1][1:0], read_ff[0][1:0], 2'b00};
      end
      `TRR_IDX_STATUS: begin
        rd_val = {2'b00, sts_ff};
      end
      `TRR_IDX_R1_LOW: begin
        rd_val = lim_lo_ff[0];
      end
      `TRR_IDX_R1_HIGH: begin
        rd_val = lim_hi_ff[0];
      end
      `TRR_IDX_LOC_LOW: begin
        rd_val = lim_lo_ff[1];
      end
      `TRR_IDX_LOC_HIGH: begin
        rd_val = lim_hi_ff[1];
      end
      `TRR_IDX_R2_LOW: begin
        rd_val = lim_lo_ff[2];
      end
      `TRR_IDX_R2_HIGH: begin
        rd_val = lim_hi_ff[2];
      end
      `TRR_IDX_R1_OFFSET: begin
        rd_val = off_ff[0];
      end
      `TRR_IDX_LOC_OFFSET: begin
        rd_val = off_ff[1];
      end
      `TRR_IDX_R2_OFFSET: begin
        rd_val = off_ff[2];
      end
      `TRR_IDX_MASK: begin
        rd_val = {2'b00, mask_ff};
      end
      `TRR_IDX_CONFIG: begin
        rd_val = {6'h00, cfg_ff};
      end
      `TRR_IDX_ALERT_CTRL: begin
        rd_val = {7'h00, alert_en_ff};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (!aligned) begin
      rd_hit = 1'b0;
      rd_val = 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------------
  // Captured in setup, held through the access phase
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= (i_pwrite || !rd_hit) ? 32'h0000_0000 : {24'h00_0000, rd_val};
      pslverr_ff <= ~rd_hit;
    end
  end

  assign o_pready = access;
  assign o_prdata = prdata_ff;
  assign o_pslverr = access & pslverr_ff;

endmodule // trr_top
`default_nettype wire

// *** shared/trr_map.vh ***
// Register indices, field positions, reset values and codes of the temperature result block
`ifndef TRR_MAP_VH
`define TRR_MAP_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TRR_IDX_R1_READ 8'h25
`define TRR_IDX_LOC_READ 8'h26
`define TRR_IDX_R2_READ 8'h27
`define TRR_IDX_STATUS 8'h41
`define TRR_IDX_R1_LOW 8'h4e
`define TRR_IDX_R1_HIGH 8'h4f
`define TRR_IDX_LOC_LOW 8'h50
`define TRR_IDX_LOC_HIGH 8'h51
`define TRR_IDX_R2_LOW 8'h52
`define TRR_IDX_R2_HIGH 8'h53
`define TRR_IDX_R1_OFFSET 8'h70
`define TRR_IDX_LOC_OFFSET 8'h71
`define TRR_IDX_R2_OFFSET 8'h72
`define TRR_IDX_MASK 8'h74
`define TRR_IDX_FRACTION 8'h77
`define TRR_IDX_CONFIG 8'h7c
`define TRR_IDX_ALERT_CTRL 8'h7e

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TRR_RST_LOW_LIMIT 8'h81
`define TRR_RST_HIGH_LIMIT 8'h7f
`define TRR_RST_OFFSET 8'h00
`define TRR_RST_READING 10'h000
`define TRR_RST_CONFIG 2'h0
`define TRR_RST_MASK 6'h00
`define TRR_RST_STATUS 6'h00
`define TRR_RST_ALERT_CTRL 1'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TRR_CFG_COMPAT_BIT 0
`define TRR_CFG_HALF_STEP_BIT 1
`define TRR_ALERT_EN_BIT 0

// ----------------------------------------------------------------------------
// Codes and clamp points, in quarter degrees, 12-bit signed
// ----------------------------------------------------------------------------
`define TRR_EXT_BIAS_Q 12'h100
`define TRR_EXT_MIN_Q 12'h004
`define TRR_EXT_MAX_Q 12'h3ff
`define TRR_TWOS_MIN_Q 12'hf04
`define TRR_TWOS_MAX_Q 12'h1ff
`define TRR_FAULT_TWOS 10'h200
`define TRR_FAULT_EXT 10'h000
`define TRR_NUM_CHAN 3

`endif

// *** rtl/trr_channel.v ***
// Offset correction, format encoding and limit comparison for one measurement
`timescale 1ns/1ps
`default_nettype none
`include "trr_map.vh"

module trr_channel (
  // Raw measurement
  input wire [9:0] i_raw,
  input wire i_fault,
  // Channel settings
  input wire [7:0] i_offset,
  input wire i_half_step,
  input wire i_compat,
  input wire [7:0] i_lim_lo,
  input wire [7:0] i_lim_hi,
  // Result
  output reg [9:0] o_code,
  output reg o_lo_viol,
  output reg o_hi_viol
);

  // --------------------------------------------------------------------------
  // Offset scaling and sum
  // --------------------------------------------------------------------------
  // Quarter-degree arithmetic; 12 bits cannot overflow for any input pair
  wire signed [11:0] raw_x = {{2{i_raw[9]}}, i_raw};
  wire signed [11:0] off_full = {{2{i_offset[7]}}, i_offset, 2'b00};
  wire signed [11:0] off_half = {{3{i_offset[7]}}, i_offset, 1'b0};
  wire signed [11:0] off_x = i_half_step ? off_half : off_full;
  wire signed [11:0] sum_q = raw_x + off_x;
  wire signed [11:0] ext_q = sum_q + `TRR_EXT_BIAS_Q;

  // --------------------------------------------------------------------------
  // Encoding, clamp and fault code
  // --------------------------------------------------------------------------
  // Ext clamp keeps code 0 free for the fault report
  reg [11:0] clamped;
  always @* begin
    clamped = 12'h000;
    if (i_compat) begin
      if (sum_q < $signed(`TRR_TWOS_MIN_Q)) begin
        clamped = `TRR_TWOS_MIN_Q;
      end else if (sum_q > $signed(`TRR_TWOS_MAX_Q)) begin
        clamped = `TRR_TWOS_MAX_Q;
      end else begin
        clamped = sum_q;
      end
    end else begin
      if (ext_q < $signed(`TRR_EXT_MIN_Q)) begin
        clamped = `TRR_EXT_MIN_Q;
      end else if (ext_q > $signed(`TRR_EXT_MAX_Q)) begin
        clamped = `TRR_EXT_MAX_Q;
      end else begin
        clamped = ext_q;
      end
    end
    if (i_fault) begin
      o_code = i_compat ? `TRR_FAULT_TWOS : `TRR_FAULT_EXT;
    end else begin
      o_code = clamped[9:0];
    end
  end

  // --------------------------------------------------------------------------
  // Window compare on the corrected whole-degree value
  // --------------------------------------------------------------------------
  // Signed compare in twos mode, unsigned in offset-64 mode
  always @* begin
    if (i_compat) begin
      o_hi_viol = $signed(o_code[9:2]) > $signed(i_lim_hi);
      o_lo_viol = $signed(o_code[9:2]) <= $signed(i_lim_lo);
    end else begin
      o_hi_viol = o_code[9:2] > i_lim_hi;
      o_lo_viol = o_code[9:2] <= i_lim_lo;
    end
  end

endmodule // trr_channel
`default_nettype wire

// *** verif/trr_top_properties.sv ***
// Port-level concurrent checks for the temperature result block
`timescale 1ns/1ps
`default_nettype none
`include "trr_map.vh"

module trr_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [9:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  // Converter and status
  input wire logic i_meas_valid,
  input wire logic o_alert_n,
  input wire logic o_frozen
);
  // --------------------
  // Access decode
  // --------------------
  wire acc = i_psel && i_penable;
  wire wr_acc = acc && i_pwrite;
  wire frac_rd = acc && !i_pwrite && (i_paddr[9:2] == `TRR_IDX_FRACTION);
  // Any of the three whole-degree registers releases the freeze in turn
  wire rdg_rd = acc && !i_pwrite && (i_paddr[9:2] >= `TRR_IDX_R1_READ)
                && (i_paddr[9:2] <= `TRR_IDX_R2_READ);

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Freeze arming is a read of the fraction bundle
  sequence s_frac_read;
    frac_rd;
  endsequence

  // --------------------
  // Assertions
  // --------------------
  ready_zero_wait_a: assert property (o_pready == acc)
    else $error("pready does not follow the access phase");
  err_in_access_a: assert property (o_pslverr |-> acc)
    else $error("pslverr outside an access phase");
  rdata_upper_a: assert property (o_prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  unmapped_err_a: assert property (acc && (i_paddr[9:2] == 8'h00) |-> o_pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (acc && (i_paddr[9:2] == `TRR_IDX_R1_LOW) |-> !o_pslverr)
    else $error("mapped access flagged as error");
  err_data_zero_a: assert property (acc && !i_pwrite && o_pslverr |-> o_prdata == 32'h0)
    else $error("refused read returns data");
  freeze_set_a: assert property (s_frac_read |=> o_frozen)
    else $error("fraction read did not freeze readings");
  freeze_cause_a: assert property ($rose(o_frozen) |-> $past(frac_rd))
    else $error("freeze without a fraction read");
  freeze_release_a: assert property ($fell(o_frozen) |-> $past(rdg_rd))
    else $error("freeze dropped without a reading read");
  alert_cause_a: assert property ($fell(o_alert_n) |->
    $past(i_meas_valid, 2) || $past(wr_acc) || $past(wr_acc, 2))
    else $error("alert raised without a measurement or write");
endmodule // trr_checker

bind trr_top trr_checker u_trr_checker (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_prdata(o_prdata),
  .i_meas_valid(i_meas_valid),
  .o_alert_n(o_alert_n),
  .o_frozen(o_frozen)
);
`default_nettype wire

// *** verif/trr_conv_model.sv ***
// Behavioural converter that hands measurements to the block
`timescale 1ns/1ps
`default_nettype none

module trr_conv_model (
  // Clock
  input wire logic i_clk,
  // Measurement out
  output logic o_valid,
  output logic [1:0] o_chan,
  output logic [9:0] o_temp,
  output logic o_fault
);
  // Idle lines at time zero
  initial begin
    o_valid = 1'b0;
    o_chan = 2'd3;
    o_temp = 10'h155;
    o_fault = 1'b0;
  end

  // One-cycle result pulse; stale lines are inverted so nothing leans on them
  task automatic send(input logic [1:0] ch, input logic [9:0] t, input logic f);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_chan <= ch;
    o_temp <= t;
    o_fault <= f;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_chan <= ~ch;
    o_temp <= ~t;
    o_fault <= ~f;
  endtask
endmodule // trr_conv_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking testbench for the temperature result block
`timescale 1ns/1ps
`default_nettype none
`include "trr_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR at %0t: got %h expected %h", $time, g, e); end end

module testbench;
  // --------------------
  // Signals and instances
  // --------------------
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [9:0] i_paddr = 10'h0;
  logic [31:0] i_pwdata = 32'h0;
  wire o_pready;
  wire o_pslverr;
  wire [31:0] o_prdata;
  wire o_alert_n;
  wire o_frozen;
  wire meas_valid;
  wire [1:0] meas_chan;
  wire [9:0] meas_temp;
  wire meas_fault;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  trr_top u_trr_top (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_prdata(o_prdata),
    .i_meas_valid(meas_valid),
    .i_meas_chan(meas_chan),
    .i_meas_temp(meas_temp),
    .i_meas_fault(meas_fault),
    .o_alert_n(o_alert_n),
    .o_frozen(o_frozen)
  );

  trr_conv_model u_trr_conv_model (
    .i_clk(i_sys_clk),
    .o_valid(meas_valid),
    .o_chan(meas_chan),
    .o_temp(meas_temp),
    .o_fault(meas_fault)
  );

  // 100 MHz clock
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // --------------------
  // Bus and check tasks
  // --------------------
  // One APB transfer; waits on pready, the watchdog bounds a hang
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= {idx, 2'b00};
    i_pwdata <= wd;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] ev);
    apb(1'b0, idx, 32'h0);
    `CHK({err, rd}, {1'b0, 24'h0, ev})
  endtask

  // Fraction bundle first, then the three readings, which also unfreezes
  task automatic chk_all(input logic [7:0] r1, input logic [7:0] lo, input logic [7:0] r2,
                         input logic [7:0] fr);
    rchk(`TRR_IDX_FRACTION, fr);
    rchk(`TRR_IDX_R1_READ, r1);
    rchk(`TRR_IDX_LOC_READ, lo);
    rchk(`TRR_IDX_R2_READ, r2);
  endtask

  // Clear status, deliver one result, check the fresh status
  task automatic meas(input logic [1:0] ch, input logic [9:0] t, input logic f,
                      input logic [7:0] st);
    apb(1'b1, `TRR_IDX_STATUS, 32'h3f);
    u_trr_conv_model.send(ch, t, f);
    rchk(`TRR_IDX_STATUS, st);
  endtask

  // Alert is registered after status, so two edges settle it
  task automatic alert_step(input logic [7:0] idx, input logic [7:0] v, input logic ev);
    apb(1'b1, idx, {24'h0, v});
    repeat (2) @(posedge i_sys_clk);
    `CHK(o_alert_n, ev)
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog: the full sequence needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  // --------------------
  // Test sequence
  // --------------------
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rchk(`TRR_IDX_R1_LOW + 8'(2 * i), 8'h81);
      rchk(`TRR_IDX_R1_HIGH + 8'(2 * i), 8'h7f);
      rchk(`TRR_IDX_R1_OFFSET + 8'(i), 8'h00);
    end
    // Read-only bundle ignores writes; unmapped index is refused
    apb(1'b1, `TRR_IDX_FRACTION, 32'hff);
    chk_all(8'h00, 8'h00, 8'h00, 8'h00);
    apb(1'b0, 8'h00, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Offset-64 encoding and limit edges
    meas(2'd0, 10'h064, 1'b0, 8'h01);
    chk_all(8'h59, 8'h00, 8'h00, 8'h00);
    apb(1'b1, `TRR_IDX_R1_LOW, 32'h59);
    apb(1'b1, `TRR_IDX_R1_HIGH, 32'h59);
    meas(2'd0, 10'h064, 1'b0, 8'h01);
    apb(1'b1, `TRR_IDX_R1_LOW, 32'h58);
    apb(1'b1, `TRR_IDX_R1_HIGH, 32'h58);
    meas(2'd0, 10'h064, 1'b0, 8'h02);
    alert_step(`TRR_IDX_ALERT_CTRL, 8'h01, 1'b0);
    alert_step(`TRR_IDX_MASK, 8'h02, 1'b1);
    alert_step(`TRR_IDX_MASK, 8'h00, 1'b0);
    alert_step(`TRR_IDX_ALERT_CTRL, 8'h00, 1'b1);
    // Corrections of 3 and 2 written as one sum
    apb(1'b1, `TRR_IDX_LOC_OFFSET, 32'h05);
    apb(1'b1, `TRR_IDX_LOC_HIGH, 32'h5d);
    meas(2'd1, 10'h064, 1'b0, 8'h0c);
    rchk(`TRR_IDX_LOC_READ, 8'h5e);
    apb(1'b1, `TRR_IDX_CONFIG, 32'h02);
    meas(2'd1, 10'h064, 1'b0, 8'h04);
    meas(2'd2, 10'h066, 1'b0, 8'h10);
    // Channel code 3 names no sensor, so no status may follow from it
    meas(2'd3, 10'h064, 1'b0, 8'h00);
    chk_all(8'h59, 8'h5b, 8'h59, 8'ha0);
    // New result while frozen is parked until all readings are read
    apb(1'b0, `TRR_IDX_FRACTION, 32'h0);
    u_trr_conv_model.send(2'd0, 10'h0c8, 1'b0);
    `CHK(o_frozen, 1'b1)
    rchk(`TRR_IDX_R1_READ, 8'h59);
    rchk(`TRR_IDX_R2_READ, 8'h59);
    rchk(`TRR_IDX_LOC_READ, 8'h5b);
    rchk(`TRR_IDX_R1_READ, 8'h72);
    // Twos complement mode with limits rewritten to match
    apb(1'b1, `TRR_IDX_CONFIG, 32'h01);
    apb(1'b1, `TRR_IDX_R1_LOW, 32'hc0);
    apb(1'b1, `TRR_IDX_R1_HIGH, 32'h18);
    meas(2'd0, 10'h064, 1'b0, 8'h02);
    rchk(`TRR_IDX_R1_READ, 8'h19);
    meas(2'd0, 10'h270, 1'b0, 8'h00);
    rchk(`TRR_IDX_R1_READ, 8'hc1);
    meas(2'd0, 10'h000, 1'b1, 8'h01);
    rchk(`TRR_IDX_R1_READ, 8'h80);
    apb(1'b1, `TRR_IDX_CONFIG, 32'h00);
    meas(2'd0, 10'h000, 1'b1, 8'h01);
    rchk(`TRR_IDX_R1_READ, 8'h00);
    conclude();
  end
endmodule // testbench
`default_nettype wire
